// ---- iclf_consts.vh ----
`ifndef ICLF_CONSTS_VH
`define ICLF_CONSTS_VH
// Register byte offsets.
`define ICLF_OFS_DIV 8'h04
`define ICLF_OFS_IRQ 8'h08
`define ICLF_OFS_ADDR 8'h0C
`define ICLF_OFS_TX 8'h10
`define ICLF_OFS_RX 8'h14
`define ICLF_OFS_CMD 8'h18
`define ICLF_OFS_QCTL 8'h1C
`define ICLF_OFS_QSTAT 8'h20
`define ICLF_OFS_CNT 8'h24
`define ICLF_OFS_REM 8'h28
// Command register fields.
`define ICLF_CMD_RUN 15
`define ICLF_CMD_TDIR 12
`define ICLF_CMD_ROLE 11
`define ICLF_CMD_STOP 10
`define ICLF_CMD_FNACK 9
`define ICLF_CMD_DATA 8
`define ICLF_CMD_SUB_HI 7
`define ICLF_CMD_SUB_LO 5
`define ICLF_CMD_RSTART 4
`define ICLF_CMD_LEAD_HI 3
`define ICLF_CMD_LEAD_LO 1
`define ICLF_CMD_START 0
`define ICLF_CMD_MASK 16'h9FFF
// Queue control fields.
`define ICLF_QC_TXCLR 2
`define ICLF_QC_RXCLR 1
`define ICLF_QC_NSKIP 0
// Queue status fields.
`define ICLF_QS_TXLVL_LO 12
`define ICLF_QS_RXLVL_LO 8
`define ICLF_QS_TDIR 6
`define ICLF_QS_TXFULL 5
`define ICLF_QS_TXEMPTY 4
`define ICLF_QS_RXFULL 3
`define ICLF_QS_RXEMPTY 2
`define ICLF_QS_NACK 1
`define ICLF_QS_DONE 0
// Own address field and pending flag.
`define ICLF_ADDR_LO 1
`define ICLF_IRQ_PEND 0
// Reset values.
`define ICLF_RST_CMD 16'h0000
`define ICLF_RST_BYTE 8'h00
`define ICLF_RST_ADDR 7'h00
// Queue geometry.
`define ICLF_Q_DEPTH 4'h8
// Serial clock timing: reference and core rates in MHz.
`define ICLF_REF_MHZ 16'h0018
`define ICLF_CORE_MHZ 16'h0028
`define ICLF_SCL_DIV 16'h0010
`define ICLF_QTR_PER_BIT 16'h0004
`define ICLF_QTR_SCALE (`ICLF_CORE_MHZ * `ICLF_SCL_DIV / `ICLF_QTR_PER_BIT)
`endif

// ---- iclf_queue.v ----
`timescale 1ns/1ps
`include "iclf_consts.vh"
module iclf_queue (
  // Clock and reset.
  input wire clk,
  input wire rst,
  input wire clr,
  // Fill side.
  input wire push,
  input wire [7:0] pushData,
  // Drain side.
  input wire pop,
  output wire [7:0] popData,
  // Fill state.
  output wire [3:0] level,
  output wire full,
  output wire empty
);
  reg [7:0] mem [0:7];
  reg [2:0] wrPtr_q;
  reg [2:0] rdPtr_q;
  reg [3:0] count_q;
  wire doPush;
  wire doPop;

  // A push when full and a pop when empty are dropped.
  assign doPush = push & ~full;
  assign doPop = pop & ~empty;
  assign full = (count_q == `ICLF_Q_DEPTH);
  assign empty = (count_q == 4'h0);
  assign level = count_q;
  assign popData = empty ? 8'h00 : mem[rdPtr_q];

  // Storage is written without reset; only pointers need a value.
  always @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= pushData;
    end
  end

  // Pointers and fill count; clear empties the queue in one cycle.
  always @(posedge clk) begin
    if (rst || clr) begin
      wrPtr_q <= 3'h0;
      rdPtr_q <= 3'h0;
      count_q <= 4'h0;
    end else begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + 3'h1;
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + 3'h1;
      end
      if (doPush && !doPop) begin
        count_q <= count_q + 4'h1;
      end else if (doPop && !doPush) begin
        count_q <= count_q - 4'h1;
      end
    end
  end
endmodule // iclf_queue

// ---- iclf_top.v ----
// Function
// - Own seven-bit address sits in bits 7:1, compared in target role only.
// - First queued byte of an address phase holds target address and direction.
// - Write-only transmit port pushes into an eight by eight byte queue.
// - Read-only receive port pops received bytes, oldest first.
// - Command bit 15 starts the programmed list; zero leaves it idle.
// - Command bit 11 picks target role at 0, controller role at 1.
// - Command bit 12 picks expected direction, used in target role only.
// - Bit 0 adds a start condition, bit 10 a closing stop.
// - Bits 3:1 give zero to seven first-phase address bytes.
// - Bit 4 adds a repeated start after the first address phase.
// - Bits 7:5 give zero to seven second-phase address bytes.
// - Bit 8 adds a data phase sized by the byte count register.
// - Bit 9 makes the last read byte answered with NACK.
// - Queue clear bits empty their queue and fall back by themselves.
// - Unless skipped, a write NACK flags an error and halts the list.
// - Queue status shows fill levels, full and empty flags, empties reset high.
// - Status bit 6 shows remote direction in target role.
// - NACK error flag is set by hardware, cleared by writing one.
// - Done flag reads one while no list runs, also after reset.
// - Writable byte count, read-only count of bytes still to move.
// - Serial clock is 24 MHz over sixteen times the divisor.
// - Pending flag set on completion, stop or lost arbitration; write one clears.
`timescale 1ns/1ps
`include "iclf_consts.vh"
module iclf_top (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Two-wire bus pins.
  input wire sclIn,
  output wire sclOut,
  output wire sclOe,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe
);
  // Sequencer states.
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_NEXT = 4'h1;
  localparam [3:0] ST_COND = 4'h2;
  localparam [3:0] ST_LOAD = 4'h3;
  localparam [3:0] ST_BIT = 4'h4;
  localparam [3:0] ST_END = 4'h5;
  localparam [3:0] ST_TWAIT = 4'h6;
  localparam [3:0] ST_TBIT = 4'h7;
  // List phases in their fixed order.
  localparam [2:0] PH_START = 3'h0;
  localparam [2:0] PH_ADDR1 = 3'h1;
  localparam [2:0] PH_RESTART = 3'h2;
  localparam [2:0] PH_ADDR2 = 3'h3;
  localparam [2:0] PH_DATA = 3'h4;
  localparam [2:0] PH_STOP = 3'h5;
  localparam [2:0] PH_END = 3'h6;
  // Bus condition kinds.
  localparam [1:0] K_START = 2'h0;
  localparam [1:0] K_RESTART = 2'h1;
  localparam [1:0] K_STOP = 2'h2;

  reg [15:0] cmd_q;
  reg nackSkip_q;
  reg txClr_q;
  reg rxClr_q;
  reg [6:0] ownAddr_q;
  reg [7:0] sclDiv_q;
  reg [7:0] byteTotal_q;
  reg [7:0] remain_q;
  reg nackErr_q;
  reg irqPend_q;
  reg [31:0] prdata_q;
  reg [31:0] rdMux;
  reg [3:0] st_q;
  reg [2:0] ph_q;
  reg [1:0] q_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [2:0] addrLeft_q;
  reg addrFirst_q;
  reg isData_q;
  reg rdDir_q;
  reg [1:0] kind_q;
  reg ackNack_q;
  reg sclLow_q;
  reg sdaLow_q;
  reg tAddr_q;
  reg tDir_q;
  reg tTx_q;
  reg tQuiet_q;
  reg sclPrev_q;
  reg sdaPrev_q;
  reg [15:0] acc_q;
  reg txPop_q;
  reg rxPush_q;
  reg nackSet_q;
  wire [7:0] ofs;
  wire hit;
  wire wrEn;
  wire rdEn;
  wire [7:0] txHead;
  wire [7:0] rxHead;
  wire [3:0] txLevel;
  wire [3:0] rxLevel;
  wire txFull;
  wire txEmpty;
  wire rxFull;
  wire rxEmpty;
  wire [7:0] divEff;
  wire [15:0] qtrThr;
  wire [15:0] accSum;
  wire tick;
  wire rdMode;
  wire lastNack;
  wire startDet;
  wire stopDet;
  wire sclRise;
  wire sclFall;

  // True when the offset names a mapped, word-aligned register.
  function regHit;
    input [31:0] a;
    begin
      regHit = (a[31:8] == 24'h00_0000) && (a[1:0] == 2'h0) &&
        (a[7:0] >= `ICLF_OFS_DIV) && (a[7:0] <= `ICLF_OFS_REM);
    end
  endfunction

  // Line drive {sclLow, sdaLow} for each quarter of a bus condition.
  function [1:0] condWave;
    input [1:0] kind;
    input [1:0] qtr;
    begin
      case (kind)
        K_START: condWave = qtr[1] ? 2'b11 : 2'b01;
        K_RESTART: begin
          case (qtr)
            2'h0: condWave = 2'b10;
            2'h1: condWave = 2'b00;
            2'h2: condWave = 2'b01;
            default: condWave = 2'b11;
          endcase
        end
        default: condWave = (qtr == 2'h0) ? 2'b11 :
          ((qtr == 2'h1) ? 2'b01 : 2'b00);
      endcase
    end
  endfunction

  // Transmit and receive byte queues.
  iclf_queue txQueue (
    .clk(core_clk),
    .rst(rst),
    .clr(txClr_q),
    .push(wrEn && (ofs == `ICLF_OFS_TX)),
    .pushData(pwdata[7:0]),
    .pop(txPop_q),
    .popData(txHead),
    .level(txLevel),
    .full(txFull),
    .empty(txEmpty)
  );
  iclf_queue rxQueue (
    .clk(core_clk),
    .rst(rst),
    .clr(rxClr_q),
    .push(rxPush_q),
    .pushData(sh_q),
    .pop(rdEn && (ofs == `ICLF_OFS_RX)),
    .popData(rxHead),
    .level(rxLevel),
    .full(rxFull),
    .empty(rxEmpty)
  );

  // APB decode; the slave answers with no wait states.
  assign ofs = paddr[7:0];
  assign hit = regHit(paddr);
  assign wrEn = psel & penable & pwrite & hit;
  assign rdEn = psel & penable & ~pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_q;

  // Open-drain pins only ever pull low.
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = sclLow_q;
  assign sdaOe = sdaLow_q;

  // Quarter-bit tick: 24 MHz reference scaled onto the 40 MHz core clock.
  assign divEff = (sclDiv_q == 8'h00) ? 8'h01 : sclDiv_q;
  assign qtrThr = {8'h00, divEff} * `ICLF_QTR_SCALE;
  assign accSum = acc_q + `ICLF_REF_MHZ;
  assign tick = (accSum >= qtrThr);

  // Byte direction and the final answer of a read.
  assign rdMode = isData_q & rdDir_q;
  assign lastNack = cmd_q[`ICLF_CMD_FNACK] && (remain_q == 8'h01);

  // Bus events seen from the sampled pins in target role.
  assign startDet = sclPrev_q & sclIn & sdaPrev_q & ~sdaIn;
  assign stopDet = sclPrev_q & sclIn & ~sdaPrev_q & sdaIn;
  assign sclRise = ~sclPrev_q & sclIn;
  assign sclFall = sclPrev_q & ~sclIn;

  // Read multiplexer; reserved bits read as zero.
  always @* begin
    rdMux = 32'h0000_0000;
    case (ofs)
      `ICLF_OFS_DIV: rdMux[7:0] = sclDiv_q;
      `ICLF_OFS_IRQ: rdMux[`ICLF_IRQ_PEND] = irqPend_q;
      `ICLF_OFS_ADDR: rdMux[7:`ICLF_ADDR_LO] = ownAddr_q;
      `ICLF_OFS_RX: rdMux[7:0] = rxHead;
      `ICLF_OFS_CMD: rdMux[15:0] = cmd_q;
      `ICLF_OFS_QCTL: rdMux[2:0] = {txClr_q, rxClr_q, nackSkip_q};
      `ICLF_OFS_QSTAT: begin
        rdMux[15:12] = txLevel;
        rdMux[11:8] = rxLevel;
        rdMux[`ICLF_QS_TDIR] = tDir_q;
        rdMux[`ICLF_QS_TXFULL] = txFull;
        rdMux[`ICLF_QS_TXEMPTY] = txEmpty;
        rdMux[`ICLF_QS_RXFULL] = rxFull;
        rdMux[`ICLF_QS_RXEMPTY] = rxEmpty;
        rdMux[`ICLF_QS_NACK] = nackErr_q;
        rdMux[`ICLF_QS_DONE] = (st_q == ST_IDLE);
      end
      `ICLF_OFS_CNT: rdMux[7:0] = byteTotal_q;
      `ICLF_OFS_REM: rdMux[7:0] = remain_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Software registers; a hardware set wins over a same-cycle clear.
  always @(posedge core_clk) begin
    if (rst) begin
      cmd_q <= `ICLF_RST_CMD;
      nackSkip_q <= 1'b0;
      txClr_q <= 1'b0;
      rxClr_q <= 1'b0;
      ownAddr_q <= `ICLF_RST_ADDR;
      sclDiv_q <= `ICLF_RST_BYTE;
      byteTotal_q <= `ICLF_RST_BYTE;
      nackErr_q <= 1'b0;
      irqPend_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (psel && !penable) begin
        prdata_q <= rdMux;
      end
      txClr_q <= 1'b0;
      rxClr_q <= 1'b0;
      if (wrEn && (ofs == `ICLF_OFS_CMD)) begin
        cmd_q <= pwdata[15:0] & `ICLF_CMD_MASK;
      end else if (st_q == ST_END) begin
        cmd_q[`ICLF_CMD_RUN] <= 1'b0;
      end
      if (wrEn && (ofs == `ICLF_OFS_QCTL)) begin
        txClr_q <= pwdata[`ICLF_QC_TXCLR];
        rxClr_q <= pwdata[`ICLF_QC_RXCLR];
        nackSkip_q <= pwdata[`ICLF_QC_NSKIP];
      end
      if (wrEn && (ofs == `ICLF_OFS_ADDR)) begin
        ownAddr_q <= pwdata[7:`ICLF_ADDR_LO];
      end
      if (wrEn && (ofs == `ICLF_OFS_DIV)) begin
        sclDiv_q <= pwdata[7:0];
      end
      if (wrEn && (ofs == `ICLF_OFS_CNT)) begin
        byteTotal_q <= pwdata[7:0];
      end
      if (nackSet_q) begin
        nackErr_q <= 1'b1;
      end else if (wrEn && (ofs == `ICLF_OFS_QSTAT) &&
                   pwdata[`ICLF_QS_NACK]) begin
        nackErr_q <= 1'b0;
      end
      if (st_q == ST_END) begin
        irqPend_q <= 1'b1;
      end else if (wrEn && (ofs == `ICLF_OFS_IRQ) &&
                   pwdata[`ICLF_IRQ_PEND]) begin
        irqPend_q <= 1'b0;
      end
    end
  end

  // Command-list sequencer for both roles.
  always @(posedge core_clk) begin
    txPop_q <= 1'b0;
    rxPush_q <= 1'b0;
    nackSet_q <= 1'b0;
    sclPrev_q <= sclIn;
    sdaPrev_q <= sdaIn;
    if (rst) begin
      st_q <= ST_IDLE;
      ph_q <= PH_START;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      addrLeft_q <= 3'h0;
      addrFirst_q <= 1'b0;
      isData_q <= 1'b0;
      rdDir_q <= 1'b0;
      kind_q <= K_START;
      ackNack_q <= 1'b0;
      sclLow_q <= 1'b0;
      sdaLow_q <= 1'b0;
      tAddr_q <= 1'b0;
      tDir_q <= 1'b0;
      tTx_q <= 1'b0;
      tQuiet_q <= 1'b0;
      remain_q <= 8'h00;
      acc_q <= 16'h0000;
    end else begin
      // The rate accumulator only runs while the controller shapes the bus.
      if ((st_q == ST_COND) || (st_q == ST_BIT)) begin
        acc_q <= tick ? (accSum - qtrThr) : accSum;
      end else begin
        acc_q <= 16'h0000;
      end
      case (st_q)
        ST_IDLE: begin
          if (cmd_q[`ICLF_CMD_RUN]) begin
            remain_q <= byteTotal_q;
            ph_q <= PH_START;
            rdDir_q <= 1'b0;
            st_q <= cmd_q[`ICLF_CMD_ROLE] ? ST_NEXT : ST_TWAIT;
          end
        end
        ST_NEXT: begin
          q_q <= 2'h0;
          case (ph_q)
            PH_START: begin
              ph_q <= PH_ADDR1;
              addrLeft_q <= cmd_q[3:1];
              addrFirst_q <= 1'b1;
              if (cmd_q[`ICLF_CMD_START]) begin
                kind_q <= K_START;
                st_q <= ST_COND;
              end
            end
            PH_RESTART: begin
              ph_q <= PH_ADDR2;
              addrLeft_q <= cmd_q[7:5];
              addrFirst_q <= 1'b1;
              if (cmd_q[`ICLF_CMD_RSTART]) begin
                kind_q <= K_RESTART;
                st_q <= ST_COND;
              end
            end
            PH_ADDR1, PH_ADDR2: begin
              isData_q <= 1'b0;
              if (addrLeft_q != 3'h0) begin
                st_q <= ST_LOAD;
              end else begin
                ph_q <= ph_q + 3'h1;
              end
            end
            PH_DATA: begin
              isData_q <= 1'b1;
              if (cmd_q[`ICLF_CMD_DATA] && (remain_q != 8'h00)) begin
                st_q <= ST_LOAD;
              end else begin
                ph_q <= PH_STOP;
              end
            end
            PH_STOP: begin
              ph_q <= PH_END;
              if (cmd_q[`ICLF_CMD_STOP]) begin
                kind_q <= K_STOP;
                st_q <= ST_COND;
              end
            end
            default: st_q <= ST_END;
          endcase
        end
        ST_COND: begin
          if (tick) begin
            {sclLow_q, sdaLow_q} <= condWave(kind_q, q_q);
            q_q <= q_q + 2'h1;
            if (q_q == 2'h3) begin
              st_q <= ST_NEXT;
            end
          end
        end
        ST_LOAD: begin
          bit_q <= 4'h0;
          if (rdMode) begin
            if (!rxFull) begin
              st_q <= ST_BIT;
            end
          end else if (!txEmpty) begin
            sh_q <= txHead;
            txPop_q <= 1'b1;
            st_q <= ST_BIT;
            if (addrFirst_q && !isData_q) begin
              rdDir_q <= txHead[0];
              addrFirst_q <= 1'b0;
            end
          end
        end
        ST_BIT: begin
          if (tick) begin
            case (q_q)
              2'h0: begin
                sclLow_q <= 1'b1;
                if (bit_q != 4'h8) begin
                  sdaLow_q <= ~rdMode & ~sh_q[7];
                end else begin
                  sdaLow_q <= rdMode & ~lastNack;
                end
                q_q <= 2'h1;
              end
              2'h1: begin
                sclLow_q <= 1'b0;
                q_q <= 2'h2;
              end
              2'h2: begin
                // Waits here while a target stretches the clock.
                if (sclIn) begin
                  q_q <= 2'h3;
                  if (bit_q == 4'h8) begin
                    ackNack_q <= sdaIn;
                  end else if (!rdMode && sh_q[7] && !sdaIn) begin
                    sclLow_q <= 1'b0;
                    sdaLow_q <= 1'b0;
                    st_q <= ST_END;
                  end else begin
                    sh_q <= {sh_q[6:0], sdaIn};
                  end
                end
              end
              default: begin
                sclLow_q <= 1'b1;
                q_q <= 2'h0;
                if (bit_q != 4'h8) begin
                  bit_q <= bit_q + 4'h1;
                end else begin
                  st_q <= ST_NEXT;
                  rxPush_q <= rdMode;
                  if (isData_q) begin
                    remain_q <= remain_q - 8'h01;
                  end else begin
                    addrLeft_q <= addrLeft_q - 3'h1;
                  end
                  if (!rdMode && ackNack_q && !nackSkip_q) begin
                    nackSet_q <= 1'b1;
                    ph_q <= PH_STOP;
                  end
                end
              end
            endcase
          end
        end
        ST_TWAIT: begin
          if (startDet) begin
            st_q <= ST_TBIT;
            bit_q <= 4'h0;
            tAddr_q <= 1'b1;
            tTx_q <= 1'b0;
            tQuiet_q <= 1'b0;
          end
        end
        ST_TBIT: begin
          if (stopDet) begin
            sdaLow_q <= 1'b0;
            st_q <= ST_END;
          end else if (startDet) begin
            bit_q <= 4'h0;
            tAddr_q <= 1'b1;
            tTx_q <= 1'b0;
            tQuiet_q <= 1'b0;
            sdaLow_q <= 1'b0;
          end else if (sclRise) begin
            if (bit_q != 4'h8) begin
              sh_q <= {sh_q[6:0], sdaIn};
            end else if (tTx_q && sdaIn) begin
              tQuiet_q <= 1'b1;
            end
          end else if (sclFall && !tQuiet_q) begin
            if (bit_q == 4'h7) begin
              bit_q <= 4'h8;
              if (tAddr_q) begin
                // Answer only our own address in the expected direction.
                if ((sh_q[7:1] == ownAddr_q) &&
                    (sh_q[0] == cmd_q[`ICLF_CMD_TDIR])) begin
                  sdaLow_q <= 1'b1;
                  tDir_q <= sh_q[0];
                  tTx_q <= sh_q[0];
                end else begin
                  st_q <= ST_TWAIT;
                end
              end else if (!tTx_q && !rxFull) begin
                sdaLow_q <= 1'b1;
                rxPush_q <= 1'b1;
                remain_q <= (remain_q == 8'h00) ? 8'h00 : remain_q - 8'h01;
              end else begin
                sdaLow_q <= 1'b0;
              end
            end else if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              tAddr_q <= 1'b0;
              sdaLow_q <= 1'b0;
              if (tTx_q) begin
                // An empty queue sends all ones.
                sh_q <= txEmpty ? 8'hFF : txHead;
                txPop_q <= ~txEmpty;
                sdaLow_q <= ~txEmpty & ~txHead[7];
                remain_q <= (remain_q == 8'h00) ? 8'h00 : remain_q - 8'h01;
              end
            end else begin
              bit_q <= bit_q + 4'h1;
              sdaLow_q <= tTx_q & ~sh_q[7];
            end
          end
        end
        ST_END: begin
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // iclf_top

// ---- iclf_chk.sv ----
`timescale 1ns/1ps
module iclf_chk (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // APB slave side.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pin drivers.
  input wire sclOe,
  input wire sdaOe
);
  // rdAcc marks a read access.
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire rdAcc = psel && penable && !pwrite;
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_hole;
    psel && !penable && paddr[7:0] == 8'h00 ##1 penable
      |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_hole: assert property (p_hole) else $error("hole");
  property p_map; psel && penable && paddr[7:0] == 8'h20 |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("status err");
  property p_wo; rdAcc && paddr[7:0] == 8'h10 |-> prdata == 32'h0000_0000;
  endproperty
  a_wo: assert property (p_wo) else $error("tx port read");
  property p_cmd;
    rdAcc && paddr[7:0] == 8'h18 |-> prdata[31:16] == 16'h0000 && !prdata[14]
      && !prdata[13];
  endproperty
  a_cmd: assert property (p_cmd) else $error("cmd spare bits");
  property p_lvl;
    rdAcc && paddr[7:0] == 8'h20 |-> prdata[5] == (prdata[15:12] == 4'h8)
      && prdata[4] == (prdata[15:12] == 4'h0);
  endproperty
  a_lvl: assert property (p_lvl) else $error("tx flags");
  property p_rxl;
    rdAcc && paddr[7:0] == 8'h20 |-> prdata[3] == (prdata[11:8] == 4'h8)
      && prdata[2] == (prdata[11:8] == 4'h0);
  endproperty
  a_rxl: assert property (p_rxl) else $error("rx flags");
  property p_cnt; rdAcc && paddr[7:0] == 8'h28 |-> prdata[31:8] == 24'h00_0000;
  endproperty
  a_cnt: assert property (p_cnt) else $error("remain width");
  property p_rst; $fell(rst) |-> !sclOe && !sdaOe; endproperty
  a_rst: assert property (p_rst) else $error("pins after reset");
  // Main scenarios reached.
  c_start: cover property ($rose(sdaOe) && !sclOe);
  c_hole: cover property (pslverr);
  c_clk: cover property ($fell(sclOe));
endmodule // iclf_chk

// ---- iclf_bus_model.sv ----
`timescale 1ns/1ps
module iclf_bus_model #(
  parameter logic [6:0] ADDR = 7'h52
) (
  // Bus levels and a commanded refusal of written data.
  input wire logic scl,
  input wire logic sda,
  input wire logic nackData,
  // Own pull on the data line.
  output logic sdaOe,
  // Each finished byte with its ninth bit.
  output logic seenStb,
  output logic [8:0] seenVal
);
  int bitNo = 9;
  logic [7:0] sh = 8'h00;
  logic [7:0] rdB = 8'h3C;
  logic addrPh = 0;
  logic rd = 0;
  logic on = 0;
  initial begin
    sdaOe = 0;
    seenStb = 0;
    seenVal = 9'h000;
  end
  // A start or repeated start makes the next byte an address.
  always @(negedge sda) begin
    if (scl) begin
      bitNo = 0;
      addrPh = 1;
      rd = 0;
      on = 1;
      sdaOe = 0;
    end
  end
  // A stop releases the line.
  always @(posedge sda) begin
    if (scl) begin
      on = 0;
      sdaOe = 0;
    end
  end
  // Shift on rising clock; the ninth rise closes the byte.
  always @(posedge scl) begin
    if (on && bitNo < 8) begin
      sh = {sh[6:0], sda};
      bitNo++;
    end else if (on && bitNo == 8) begin
      seenVal = {sh, sda};
      seenStb = ~seenStb;
      bitNo = 9;
    end
  end
  // Change the line only while the clock is low.
  always @(negedge scl) begin
    if (on && bitNo == 8) begin
      if (addrPh) rd = sh[0];
      if (addrPh) on = sh[7:1] == ADDR;
      sdaOe = on && (addrPh || (!rd && !nackData));
    end else if (on && bitNo == 9) begin
      if (rd && !addrPh && seenVal[0]) on = 0;
      if (rd && !addrPh) rdB = rdB + 8'h01;
      addrPh = 0;
      bitNo = 0;
      sdaOe = on && rd && !rdB[7];
    end else if (on && rd && bitNo < 8) begin
      sdaOe = !rdB[7 - bitNo];
    end
  end
endmodule // iclf_bus_model

// ---- tb_iclf_top.sv ----
`timescale 1ns/1ps
bind iclf_top iclf_chk chk (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sclOe(sclOe), .sdaOe(sdaOe));
module tb_iclf_top;
  localparam logic [6:0] TA = 7'h52;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic nackData = 0;
  logic [31:0] paddr = 0, pwdata = 0, v, rnd = 32'h0001_1324;
  wire [31:0] prdata;
  wire pready, pslverr, sclOe, sdaOe, modelOe, seenStb;
  wire [8:0] seenVal;
  wire sclW = ~sclOe;
  wire sdaW = ~(sdaOe | modelOe);
  int fails = 0, checks = 0;
  logic [32:0] expQ[$], mskQ[$];
  logic [8:0] wireQ[$];
  iclf_top uut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclW),
    .sclOut(), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(), .sdaOe(sdaOe));
  iclf_bus_model #(.ADDR(TA)) peer (.scl(sclW), .sda(sdaW),
    .nackData(nackData), .sdaOe(modelOe), .seenStb(seenStb),
    .seenVal(seenVal));
  // Core clock.
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp(input string n, input logic [32:0] e, g, m);
    checks++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    v = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
    if (n >= 50) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, m);
    expQ.push_back(e);
    mskQ.push_back(m);
    apb(0, a, 32'h0000_0000);
  endtask
  task automatic push(input logic [7:0] b, input logic [8:0] w);
    apb(1, 8'h10, {24'h00_0000, b});
    wireQ.push_back(w);
  endtask
  task automatic run(input logic [31:0] c);
    int n;
    n = 0;
    apb(1, 8'h18, c);
    do begin
      apb(0, 8'h20, 32'h0000_0000);
      n++;
    end while (v[0] !== 1'b1 && n < 800);
    if (n >= 800) begin
      fails++;
      end_of_test();
    end
  endtask
  // Read answers, taken at the access edge.
  always @(posedge core_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && expQ.size() > 0)
      cmp("read", expQ.pop_front(), {pslverr, prdata},
        mskQ.pop_front() | 33'h1_0000_0000);
  end
  // Bytes seen on the wire.
  always @(seenStb) begin
    if (!rst)
      cmp("wire", {24'h00_0000, wireQ.pop_front()}, {24'h00_0000, seenVal},
        33'h1FF);
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    for (int a = 12; a <= 40; a += 4)
      rd(a[7:0], a == 32 ? 33'h15 : 33'h0, ~33'h0);
    rd(8'h00, 33'h1_0000_0000, ~33'h0);
    $display("test reset done");
    rnd = xs(rnd);
    apb(1, 8'h0C, rnd);
    rd(8'h0C, {25'h000_0000, rnd[7:1], 1'b0}, ~33'h0);
    apb(1, 8'h18, rnd & 32'h0000_1FFF);
    rd(8'h18, {1'b0, rnd & 32'h0000_1FFF}, ~33'h0);
    rd(8'h20, 33'h1, 33'h1);
    apb(1, 8'h18, 32'h0000_0000);
    apb(1, 8'h24, rnd >> 8);
    apb(1, 8'h28, 32'h0000_00FF);
    rd(8'h24, {25'h000_0000, rnd[15:8]}, ~33'h0);
    rd(8'h28, 33'h0, ~33'h0);
    $display("test registers done");
    for (int i = 0; i < 9; i++) apb(1, 8'h10, i);
    rd(8'h20, 33'h8025, ~33'h0);
    apb(1, 8'h1C, 32'h0000_0006);
    rd(8'h1C, 33'h0, ~33'h0);
    rd(8'h20, 33'h15, ~33'h0);
    $display("test queues done");
    apb(1, 8'h04, 32'h0000_0001);
    push({TA, 1'b0}, {TA, 2'b00});
    push(rnd[7:0], {rnd[7:0], 1'b0});
    push(rnd[15:8], {rnd[15:8], 1'b0});
    apb(1, 8'h24, 32'h0000_0002);
    run(32'h0000_8D03);
    rd(8'h28, 33'h0, ~33'h0);
    rd(8'h08, 33'h1, 33'h1);
    apb(1, 8'h08, 32'h0000_0001);
    rd(8'h08, 33'h0, 33'h1);
    $display("test write done");
    push({TA, 1'b0}, {TA, 2'b00});
    push(rnd[23:16], {rnd[23:16], 1'b0});
    push({TA, 1'b1}, {TA, 2'b10});
    wireQ.push_back(9'h078);
    wireQ.push_back(9'h07B);
    run(32'h0000_8F35);
    rd(8'h14, 33'h3C, ~33'h0);
    rd(8'h14, 33'h3D, ~33'h0);
    rd(8'h20, 33'h15, ~33'h0);
    $display("test read done");
    nackData <= 1;
    push({TA, 1'b0}, {TA, 2'b00});
    push(rnd[7:0], {rnd[7:0], 1'b1});
    apb(1, 8'h10, rnd & 32'h0000_00FF);
    run(32'h0000_8D03);
    rd(8'h20, 33'h3, 33'h3);
    apb(1, 8'h20, 32'h0000_0002);
    rd(8'h20, 33'h1, 33'h3);
    apb(1, 8'h1C, 32'h0000_0005);
    push({TA, 1'b0}, {TA, 2'b00});
    push(rnd[7:0], {rnd[7:0], 1'b1});
    push(rnd[15:8], {rnd[15:8], 1'b1});
    run(32'h0000_8D03);
    rd(8'h20, 33'h11, 33'h13);
    $display("test nack done");
    cmp("wire left", 33'h0, wireQ.size(), ~33'h0);
    end_of_test();
  end
endmodule // tb_iclf_top
